// >>> hw/sts_pkg.sv
// Shared constants and types of the supply and thermal supervisor.
// Assumes a single 200 MHz system clock; all times derive from it.
package sts_pkg;

  // System clock rate
  localparam int CLK_HZ = 200_000_000;

  // Documented typical times, in their own units
  localparam int SC_FILTER_MS = 4;
  localparam int COOL_DOWN_S = 1;
  localparam int RESET_DELAY_MS = 2;

  // Cycle counts derived from the times
  localparam int SC_FILTER_CYC = SC_FILTER_MS * (CLK_HZ / 1000);
  localparam int COOL_DOWN_CYC = COOL_DOWN_S * CLK_HZ;
  localparam int RESET_DELAY_CYC = RESET_DELAY_MS * (CLK_HZ / 1000);

  // Widths, counts and limits
  localparam int SEC_EN_W = 2;
  localparam int HS_COUNT = 4;
  localparam int HS_MAX = 8;
  localparam int SYNC_FIXED = 12;

  // Field codes and reset values
  localparam logic [1:0] CAN_FAIL_NONE = 2'h0;
  localparam logic [1:0] CAN_FAIL_FIRST_LEVEL_OVERTEMP_FLAG = 2'h1;
  localparam logic [SEC_EN_W-1:0] SEC_EN_RESET = 2'h0;
  localparam logic FLAG_RESET = 1'b0;

  typedef enum logic [1:0] {
    ST_RESTART,
    ST_NORMAL,
    ST_FS_SHORT,
    ST_FS_THERMAL
  } sts_mode_t;

  localparam sts_mode_t MODE_RESET = ST_RESTART;

endpackage : sts_pkg

// >>> hw/sts_sync.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/10ps
module sts_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  generate
    if (W < 1)
    begin : g_bad_width
      $error("sts_sync: width must be at least one");
    end
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      logic meta_r;
      logic q_r;
      always_ff @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          meta_r <= 1'b0;
          q_r <= 1'b0;
        end
        else
        begin
          meta_r <= d_i[i];
          q_r <= meta_r;
        end
      end
      assign q_o[i] = q_r;
    end
  endgenerate

endmodule : sts_sync

// >>> hw/sts_timer.sv
// Interval timer: done rises after LIMIT consecutive cycles of run.
// Assumes run drops to restart the interval; done is registered.
`timescale 1ns/10ps
module sts_timer #(
  parameter int LIMIT = 1
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic run_i,
  output logic done_o
);

  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] cnt_r;
  logic done_r;

  generate
    if (LIMIT < 1)
    begin : g_bad_limit
      $error("sts_timer: limit must be at least one");
    end
  endgenerate

  // Saturates at the last value so done holds while run stays high
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_r <= '0;
    else if (!run_i)
      cnt_r <= '0;
    else if (cnt_r != LAST)
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      done_r <= 1'b0;
    else
      done_r <= run_i && (cnt_r == LAST);
  end

  assign done_o = done_r;

endmodule : sts_timer

// >>> hw/sts_supervisor.sv
// Supply and thermal supervisor: sticky flags, stage shutdowns, modes.
// Assumes comparator levels on inputs and one-cycle clear/write strobes from the SPI side.
//
// Behaviour
// (RULE_01) Main output never rises: short, fail-safe
// (RULE_02) Main output low too long: same
// (RULE_03) Short check only with battery ok
// (RULE_04) Leave short fail-safe only on wake
// (RULE_05) No short flag during normal ramp
// (RULE_06) Sticky low flags, cleared by SPI
// (RULE_07) No secondary-low flag while switching
// (RULE_08) First thermal level switches block off
// (RULE_09) First thermal level only while on
// (RULE_10) Secondary overtemp clears enables, sets status
// (RULE_11) CAN overtemp: receive only, fail 01
// (RULE_12) High-side overtemp: all off, status set
// (RULE_13) Thermal bits clear only when cool
// (RULE_14) Prewarning only with main regulator on
// (RULE_15) Second level: cool-down, restart, normal
// (RULE_16) Second-level flag clears in normal, cool
// (RULE_17) Short filter lasts 4 ms
// (RULE_18) Cool-down lasts 1 s
// (RULE_19) Reset delay starts at threshold crossing
// (RULE_20) Inputs synchronised, intervals counted by clock
// (RULE_21) Flags readable, everything reset at power-on
`timescale 1ns/10ps
module sts_supervisor #(
  parameter int N_HS = sts_pkg::HS_COUNT,
  parameter int SC_FILTER_CYCLES = sts_pkg::SC_FILTER_CYC,
  parameter int COOL_DOWN_CYCLES = sts_pkg::COOL_DOWN_CYC,
  parameter int RESET_DELAY_CYCLES = sts_pkg::RESET_DELAY_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic main_above_rt_i,
  input wire logic vs_above_uv_i,
  input wire logic sec_output_low_i,
  input wire logic transceiver_supply_low_i,
  input wire logic sec_switching_i,
  input wire logic sec_overtemp_i,
  input wire logic can_overtemp_i,
  input wire logic [N_HS-1:0] hs_overtemp_i,
  input wire logic prewarn_temp_i,
  input wire logic second_level_temp_i,
  input wire logic wake_can_i,
  input wire logic wake_inputs_i,
  input wire logic can_stage_on_i,
  input wire logic sec_enable_we_i,
  input wire logic [sts_pkg::SEC_EN_W-1:0] sec_enable_data_i,
  input wire logic hs_control_we_i,
  input wire logic [N_HS-1:0] hs_control_data_i,
  input wire logic clr_short_i,
  input wire logic clr_failure_i,
  input wire logic clr_sec_low_i,
  input wire logic clr_transceiver_low_i,
  input wire logic clr_first_level_i,
  input wire logic clr_sec_overtemp_i,
  input wire logic clr_can_fail_i,
  input wire logic clr_hs_fault_i,
  input wire logic clr_prewarning_i,
  input wire logic clr_second_level_i,
  output logic main_reg_en_o,
  output logic reset_output_n_o,
  output logic fail_outputs_o,
  output logic failure_flag_o,
  output logic [1:0] mode_o,
  output logic main_output_short_flag_o,
  output logic secondary_output_low_flag_o,
  output logic transceiver_supply_low_flag_o,
  output logic first_level_overtemp_flag_o,
  output logic second_level_overtemp_flag_o,
  output logic temperature_prewarning_flag_o,
  output logic [sts_pkg::SEC_EN_W-1:0] secondary_output_enable_bits_o,
  output logic secondary_output_overtemp_status_o,
  output logic [N_HS-1:0] high_side_control_o,
  output logic [N_HS-1:0] high_side_fault_status_o,
  output logic can_tx_en_o,
  output logic [1:0] can_fail_o
);

  localparam int NSYNC = sts_pkg::SYNC_FIXED + N_HS;

  generate
    if (N_HS < 1 || N_HS > sts_pkg::HS_MAX)
    begin : g_bad_hs
      $error("sts_supervisor: high-side count out of range");
    end
  endgenerate

  // Set wins over clear, so an event in the clear cycle survives
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic main_above_s, vs_ok_s, sec_low_s, can_low_s, sec_sw_s, ot_sec_s, ot_can_s;
  logic prewarn_s, second_level_overtemp_flag_s, wake_can_s, wake_hv_s, can_on_s;
  logic [N_HS-1:0] ot_hs_s;

  // (RULE_20) synchronise all comparators
  assign raw_in = {hs_overtemp_i, can_stage_on_i, wake_inputs_i, wake_can_i, second_level_temp_i,
                   prewarn_temp_i, can_overtemp_i, sec_overtemp_i, sec_switching_i, transceiver_supply_low_i,
                   sec_output_low_i, vs_above_uv_i, main_above_rt_i};

  sts_sync #(.W(NSYNC)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .d_i(raw_in),
    .q_o(syn)
  );

  assign main_above_s = syn[0];
  assign vs_ok_s = syn[1];
  assign sec_low_s = syn[2];
  assign can_low_s = syn[3];
  assign sec_sw_s = syn[4];
  assign ot_sec_s = syn[5];
  assign ot_can_s = syn[6];
  assign prewarn_s = syn[7];
  assign second_level_overtemp_flag_s = syn[8];
  assign wake_can_s = syn[9];
  assign wake_hv_s = syn[10];
  assign can_on_s = syn[11];
  assign ot_hs_s = syn[NSYNC-1:sts_pkg::SYNC_FIXED];

  sts_pkg::sts_mode_t mode_r, mode_nxt;
  logic main_reg_en_r, rst_n_r, fail_out_r, failure_r, short_r;
  logic sec_low_r, can_low_r, first_level_overtemp_flag_r, second_level_overtemp_flag_r, tpw_r, sec_ot_r, can_tx_r;
  logic [sts_pkg::SEC_EN_W-1:0] sec_en_r;
  logic [N_HS-1:0] hs_ctrl_r, hs_fault_r;
  logic [1:0] can_fail_r;
  logic sc_run, sc_done, cool_run, cool_done, rd_run, rd_done;
  logic second_level_overtemp_flag_evt, sec_first_level_overtemp_flag, can_first_level_overtemp_flag, hs_first_level_overtemp_flag, first_level_overtemp_flag_hot;

  // (RULE_03) short check gated by battery level
  // (RULE_05) ramp shorter than the filter sets nothing
  assign sc_run = main_reg_en_r && vs_ok_s && !main_above_s;
  assign cool_run = (mode_r == sts_pkg::ST_FS_THERMAL);
  // (RULE_19) reset delay counts from threshold crossing
  assign rd_run = (mode_r == sts_pkg::ST_RESTART) && main_above_s;

  // (RULE_17) short filter interval
  sts_timer #(.LIMIT(SC_FILTER_CYCLES)) u_sc_timer (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .run_i(sc_run),
    .done_o(sc_done)
  );

  // (RULE_18) cool-down interval
  sts_timer #(.LIMIT(COOL_DOWN_CYCLES)) u_cool_timer (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .run_i(cool_run),
    .done_o(cool_done)
  );

  sts_timer #(.LIMIT(RESET_DELAY_CYCLES)) u_rd_timer (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .run_i(rd_run),
    .done_o(rd_done)
  );

  // (RULE_16) second level watched only with main regulator on
  assign second_level_overtemp_flag_evt = second_level_overtemp_flag_s && main_reg_en_r;
  // (RULE_09) first level evaluated only for blocks that are on
  assign sec_first_level_overtemp_flag = ot_sec_s && (|sec_en_r);
  assign can_first_level_overtemp_flag = ot_can_s && can_on_s;
  assign hs_first_level_overtemp_flag = |(ot_hs_s & hs_ctrl_r);
  assign first_level_overtemp_flag_hot = ot_sec_s || ot_can_s || (|ot_hs_s);

  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      sts_pkg::ST_RESTART, sts_pkg::ST_NORMAL:
      begin
        // (RULE_01) short during start-up
        // (RULE_02) short during operation
        if (sc_done)
          mode_nxt = sts_pkg::ST_FS_SHORT;
        // (RULE_15) second level enters fail-safe
        else if (second_level_overtemp_flag_evt)
          mode_nxt = sts_pkg::ST_FS_THERMAL;
        else if (mode_r == sts_pkg::ST_RESTART && rd_done)
          mode_nxt = sts_pkg::ST_NORMAL;
        else if (mode_r == sts_pkg::ST_NORMAL && !main_above_s)
          mode_nxt = sts_pkg::ST_RESTART;
      end
      sts_pkg::ST_FS_SHORT:
      begin
        // (RULE_04) only a wake reactivates
        if (wake_can_s || wake_hv_s)
          mode_nxt = sts_pkg::ST_RESTART;
      end
      sts_pkg::ST_FS_THERMAL:
      begin
        if (cool_done)
          mode_nxt = sts_pkg::ST_RESTART;
      end
    endcase
  end

  // (RULE_21) power-on reset of mode state
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode_r <= sts_pkg::MODE_RESET;
      main_reg_en_r <= 1'b1;
      rst_n_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      main_reg_en_r <= (mode_nxt == sts_pkg::ST_RESTART) || (mode_nxt == sts_pkg::ST_NORMAL);
      rst_n_r <= (mode_nxt == sts_pkg::ST_NORMAL);
    end
  end

  // (RULE_01) short flag, failure flag and fail outputs
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      short_r <= sts_pkg::FLAG_RESET;
      failure_r <= sts_pkg::FLAG_RESET;
      fail_out_r <= sts_pkg::FLAG_RESET;
    end
    else
    begin
      short_r <= sticky(short_r, mode_nxt == sts_pkg::ST_FS_SHORT && mode_r != sts_pkg::ST_FS_SHORT, clr_short_i);
      failure_r <= sticky(failure_r, mode_nxt == sts_pkg::ST_FS_SHORT, clr_failure_i);
      fail_out_r <= sticky(fail_out_r, mode_nxt == sts_pkg::ST_FS_SHORT || mode_nxt == sts_pkg::ST_FS_THERMAL,
                           clr_failure_i && mode_r == sts_pkg::ST_NORMAL);
    end
  end

  // (RULE_06) sticky undervoltage flags
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sec_low_r <= sts_pkg::FLAG_RESET;
      can_low_r <= sts_pkg::FLAG_RESET;
    end
    else
    begin
      // (RULE_07) suppressed while regulator switches
      sec_low_r <= sticky(sec_low_r, sec_low_s && (|sec_en_r) && !sec_sw_s, clr_sec_low_i);
      can_low_r <= sticky(can_low_r, can_low_s, clr_transceiver_low_i);
    end
  end

  // (RULE_08) first level switches blocks off
  // (RULE_10) secondary enables cleared until rewritten
  // (RULE_12) all high-side controls cleared
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sec_en_r <= sts_pkg::SEC_EN_RESET;
      hs_ctrl_r <= '0;
    end
    else
    begin
      if (sec_first_level_overtemp_flag)
        sec_en_r <= '0;
      else if (sec_enable_we_i)
        sec_en_r <= sec_enable_data_i;
      if (hs_first_level_overtemp_flag)
        hs_ctrl_r <= '0;
      else if (hs_control_we_i)
        hs_ctrl_r <= hs_control_data_i;
    end
  end

  // (RULE_13) thermal bits clear only when cool
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      first_level_overtemp_flag_r <= sts_pkg::FLAG_RESET;
      sec_ot_r <= sts_pkg::FLAG_RESET;
      hs_fault_r <= '0;
      can_fail_r <= sts_pkg::CAN_FAIL_NONE;
      can_tx_r <= 1'b1;
    end
    else
    begin
      first_level_overtemp_flag_r <= sticky(first_level_overtemp_flag_r, sec_first_level_overtemp_flag || can_first_level_overtemp_flag || hs_first_level_overtemp_flag, clr_first_level_i && !first_level_overtemp_flag_hot);
      sec_ot_r <= sticky(sec_ot_r, sec_first_level_overtemp_flag, clr_sec_overtemp_i && !ot_sec_s);
      hs_fault_r <= (ot_hs_s & hs_ctrl_r) | (hs_fault_r & ~({N_HS{clr_hs_fault_i}} & ~ot_hs_s));
      // (RULE_11) receive only, failure code, automatic recovery
      can_tx_r <= !can_first_level_overtemp_flag;
      if (can_first_level_overtemp_flag)
        can_fail_r <= sts_pkg::CAN_FAIL_FIRST_LEVEL_OVERTEMP_FLAG;
      else if (clr_can_fail_i && !ot_can_s)
        can_fail_r <= sts_pkg::CAN_FAIL_NONE;
    end
  end

  // (RULE_14) prewarning with regulator on
  // (RULE_16) second-level flag clears in normal mode
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tpw_r <= sts_pkg::FLAG_RESET;
      second_level_overtemp_flag_r <= sts_pkg::FLAG_RESET;
    end
    else
    begin
      tpw_r <= sticky(tpw_r, prewarn_s && main_reg_en_r, clr_prewarning_i && !prewarn_s);
      second_level_overtemp_flag_r <= sticky(second_level_overtemp_flag_r, second_level_overtemp_flag_evt, clr_second_level_i && !second_level_overtemp_flag_s && mode_r == sts_pkg::ST_NORMAL);
    end
  end

  // (RULE_21) flags presented as status
  assign main_reg_en_o = main_reg_en_r;
  assign reset_output_n_o = rst_n_r;
  assign fail_outputs_o = fail_out_r;
  assign failure_flag_o = failure_r;
  assign mode_o = mode_r;
  assign main_output_short_flag_o = short_r;
  assign secondary_output_low_flag_o = sec_low_r;
  assign transceiver_supply_low_flag_o = can_low_r;
  assign first_level_overtemp_flag_o = first_level_overtemp_flag_r;
  assign second_level_overtemp_flag_o = second_level_overtemp_flag_r;
  assign temperature_prewarning_flag_o = tpw_r;
  assign secondary_output_enable_bits_o = sec_en_r;
  assign secondary_output_overtemp_status_o = sec_ot_r;
  assign high_side_control_o = hs_ctrl_r;
  assign high_side_fault_status_o = hs_fault_r;
  assign can_tx_en_o = can_tx_r;
  assign can_fail_o = can_fail_r;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  property p_sc_entry;
    sc_done && (mode_r == sts_pkg::ST_RESTART || mode_r == sts_pkg::ST_NORMAL) |=>
      mode_r == sts_pkg::ST_FS_SHORT && short_r && !main_reg_en_r;
  endproperty
  a_sc_entry: assert property (p_sc_entry) else $error("short did not enter fail-safe"); // RULE_01

  property p_vs_gate;
    !vs_ok_s [*2] |=> !(mode_r == sts_pkg::ST_FS_SHORT && $past(mode_r) != sts_pkg::ST_FS_SHORT);
  endproperty
  a_vs_gate: assert property (p_vs_gate) else $error("short taken with battery low"); // RULE_03

  property p_fs_hold;
    mode_r == sts_pkg::ST_FS_SHORT && !wake_can_s && !wake_hv_s |=> mode_r == sts_pkg::ST_FS_SHORT;
  endproperty
  a_fs_hold: assert property (p_fs_hold) else $error("short fail-safe left without wake"); // RULE_04

  property p_sec_low_cause;
    $rose(sec_low_r) |-> $past(sec_low_s && !sec_sw_s && (|sec_en_r));
  endproperty
  a_sec_low_cause: assert property (p_sec_low_cause) else $error("secondary low flag set while switching"); // RULE_07

  property p_sec_first_level_overtemp_flag;
    sec_first_level_overtemp_flag |=> sec_en_r == '0 && sec_ot_r && first_level_overtemp_flag_r;
  endproperty
  a_sec_first_level_overtemp_flag: assert property (p_sec_first_level_overtemp_flag) else $error("secondary overtemp not handled"); // RULE_10

  property p_can_first_level_overtemp_flag;
    can_first_level_overtemp_flag |=> !can_tx_r && can_fail_r == sts_pkg::CAN_FAIL_FIRST_LEVEL_OVERTEMP_FLAG;
  endproperty
  a_can_first_level_overtemp_flag: assert property (p_can_first_level_overtemp_flag) else $error("transmitter not disabled on overtemp"); // RULE_11

  property p_hs_first_level_overtemp_flag;
    hs_first_level_overtemp_flag |=> hs_ctrl_r == '0 && first_level_overtemp_flag_r ##1 hs_ctrl_r == '0 || $past(hs_control_we_i);
  endproperty
  a_hs_first_level_overtemp_flag: assert property (p_hs_first_level_overtemp_flag) else $error("high-side switches not all off"); // RULE_12

  property p_first_level_overtemp_flag_keep;
    first_level_overtemp_flag_r && first_level_overtemp_flag_hot |=> first_level_overtemp_flag_r;
  endproperty
  a_first_level_overtemp_flag_keep: assert property (p_first_level_overtemp_flag_keep) else $error("first-level flag cleared while hot"); // RULE_13

  property p_tpw_off;
    !main_reg_en_r && !tpw_r |=> !tpw_r;
  endproperty
  a_tpw_off: assert property (p_tpw_off) else $error("prewarning set with regulator off"); // RULE_14

  property p_second_level_overtemp_flag_entry;
    second_level_overtemp_flag_evt && !sc_done |=> mode_r == sts_pkg::ST_FS_THERMAL && second_level_overtemp_flag_r && !rst_n_r;
  endproperty
  a_second_level_overtemp_flag_entry: assert property (p_second_level_overtemp_flag_entry) else $error("second level did not enter fail-safe"); // RULE_15

  property p_cool_exit;
    mode_r == sts_pkg::ST_FS_THERMAL && cool_done |=> mode_r == sts_pkg::ST_RESTART && main_reg_en_r;
  endproperty
  a_cool_exit: assert property (p_cool_exit) else $error("cool-down end did not restart"); // RULE_18

  property p_rd_release;
    mode_r == sts_pkg::ST_RESTART && rd_done && !sc_done && !second_level_overtemp_flag_evt |=> rst_n_r && mode_r == sts_pkg::ST_NORMAL;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("reset not released after delay"); // RULE_19

endmodule : sts_supervisor

// >>> verification/sts_mcu_model.sv
// Microcontroller stand-in: turns clear requests into one-cycle strobes.
// Assumes the bench raises each request for a single cycle.
`timescale 1ns/10ps
module sts_mcu_model (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [9:0] req_i,
  input wire logic hot_i,
  input wire logic obey_i,
  output logic [9:0] clr_o
);
  logic [9:0] pend_r;

  // clear only when cool
  // A polite host holds requests back while hot; obey_i low sends them anyway
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pend_r <= 10'h000;
      clr_o <= 10'h000;
    end
    else if (obey_i && hot_i)
    begin
      pend_r <= pend_r | req_i;
      clr_o <= 10'h000;
    end
    else
    begin
      clr_o <= pend_r | req_i;
      pend_r <= 10'h000;
    end
  end
endmodule : sts_mcu_model

// >>> verification/tb_top.sv
// Self-checking bench of the supervisor with random and corner cases.
// Assumes shortened interval parameters and a 200 MHz clock.
`timescale 1ns/10ps
module tb_top;
  localparam int SC = 20;
  localparam int CD = 30;
  localparam int RD = 10;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic mn = 1'b0, vs = 1'b1, slo = 1'b0, tlo = 1'b0, sw = 1'b0, sot = 1'b0, cot = 1'b0;
  logic pw = 1'b0, t2 = 1'b0, wc = 1'b0, wi = 1'b0, canon = 1'b0, s_we = 1'b0, h_we = 1'b0;
  logic obey = 1'b1;
  logic [1:0] s_d = 2'h0;
  logic [3:0] hot = 4'h0, h_d = 4'h0, b, hsc, hsf;
  logic [9:0] req = 10'h000, clr;
  logic ren, rst_n, fo, fl, f_sc, f_sl, f_tl, f_t1, f_t2, f_pw, sos, tx;
  logic [1:0] mo, sen, cf;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  sts_mcu_model sts_mcu_model_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req),
    .hot_i(|{sot, cot, hot, pw, t2}), .obey_i(obey), .clr_o(clr));

  sts_supervisor #(.N_HS(4), .SC_FILTER_CYCLES(SC), .COOL_DOWN_CYCLES(CD), .RESET_DELAY_CYCLES(RD))
  sts_supervisor_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .main_above_rt_i(mn), .vs_above_uv_i(vs),
    .sec_output_low_i(slo), .transceiver_supply_low_i(tlo), .sec_switching_i(sw), .sec_overtemp_i(sot),
    .can_overtemp_i(cot), .hs_overtemp_i(hot), .prewarn_temp_i(pw), .second_level_temp_i(t2),
    .wake_can_i(wc), .wake_inputs_i(wi), .can_stage_on_i(canon), .sec_enable_we_i(s_we),
    .sec_enable_data_i(s_d), .hs_control_we_i(h_we), .hs_control_data_i(h_d), .clr_short_i(clr[0]),
    .clr_failure_i(clr[1]), .clr_sec_low_i(clr[2]), .clr_transceiver_low_i(clr[3]),
    .clr_first_level_i(clr[4]), .clr_sec_overtemp_i(clr[5]), .clr_can_fail_i(clr[6]),
    .clr_hs_fault_i(clr[7]), .clr_prewarning_i(clr[8]), .clr_second_level_i(clr[9]),
    .main_reg_en_o(ren), .reset_output_n_o(rst_n), .fail_outputs_o(fo), .failure_flag_o(fl),
    .mode_o(mo), .main_output_short_flag_o(f_sc), .secondary_output_low_flag_o(f_sl),
    .transceiver_supply_low_flag_o(f_tl), .first_level_overtemp_flag_o(f_t1),
    .second_level_overtemp_flag_o(f_t2), .temperature_prewarning_flag_o(f_pw),
    .secondary_output_enable_bits_o(sen), .secondary_output_overtemp_status_o(sos),
    .high_side_control_o(hsc), .high_side_fault_status_o(hsf), .can_tx_en_o(tx), .can_fail_o(cf));

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // Hang guard, well above the longest scenario
  always @(posedge clk_sys_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc

  task automatic cb(input logic a, input logic e);
    tests_run++;
    if (a !== e)
    begin
      miscompares++;
      $display("BAD %0t bit %b expected %b", $time, a, e);
    end
  endtask : cb

  task automatic cv(input logic [7:0] a, input logic [7:0] e);
    tests_run++;
    if (a !== e)
    begin
      miscompares++;
      $display("BAD %0t value %h expected %h", $time, a, e);
    end
  endtask : cv

  // Bounded wait for a mode, then compare it
  task automatic wm(input logic [1:0] e, input int n);
    int k;
    k = 0;
    while (mo !== e && k < n)
    begin
      cyc(1);
      k++;
    end
    cv({6'h00, mo}, {6'h00, e});
  endtask : wm

  task automatic clq(input int idx);
    @(posedge clk_sys_i);
    req[idx] <= 1'b1;
    @(posedge clk_sys_i);
    req <= 10'h000;
    cyc(3);
  endtask : clq

  initial
  begin
    void'($urandom(32'h2bc486ae));
    cyc(20);
    cv({mo, ren, rst_n, tx, f_sc, fo, f_t2}, 8'h28);
    @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    cyc(8);
    mn <= 1'b1;
    cyc(6);
    cv({6'h00, mo}, 8'h00);
    wm(2'h1, RD + 20);
    cb(rst_n, 1'b1);
    cb(f_sc, 1'b0);
    @(posedge clk_sys_i);
    mn <= 1'b0;
    cyc(12);
    cb(f_sc, 1'b0);
    wm(2'h2, 20);
    cv({4'h0, f_sc, fl, fo, ren}, 8'h0E);
    @(posedge clk_sys_i);
    wc <= 1'b1;
    cyc(3);
    wc <= 1'b0;
    wm(2'h0, 6);
    wm(2'h2, SC + 10);
    cb(rst_n, 1'b0);
    mn <= 1'b1;
    cyc(10);
    cv({6'h00, mo}, 8'h02);
    wi <= 1'b1;
    cyc(3);
    wi <= 1'b0;
    wm(2'h0, 6);
    wm(2'h1, RD + 20);
    clq(0);
    clq(1);
    cv({6'h00, f_sc, fo}, 8'h00);
    @(posedge clk_sys_i);
    vs <= 1'b0;
    mn <= 1'b0;
    cyc(SC + 15);
    cb(f_sc, 1'b0);
    mn <= 1'b1;
    vs <= 1'b1;
    wm(2'h1, RD + 20);
    @(posedge clk_sys_i);
    s_we <= 1'b1;
    s_d <= 2'($urandom_range(1, 3));
    sw <= 1'b1;
    slo <= 1'b1;
    @(posedge clk_sys_i);
    s_we <= 1'b0;
    cyc(6);
    cb(f_sl, 1'b0);
    sw <= 1'b0;
    cyc(5);
    slo <= 1'b0;
    tlo <= 1'b1;
    cyc(5);
    tlo <= 1'b0;
    cyc(5);
    cv({6'h00, f_sl, f_tl}, 8'h03);
    clq(2);
    clq(3);
    cv({6'h00, f_sl, f_tl}, 8'h00);
    @(posedge clk_sys_i);
    s_we <= 1'b1;
    s_d <= 2'h0;
    @(posedge clk_sys_i);
    s_we <= 1'b0;
    sot <= 1'b1;
    cyc(6);
    cv({6'h00, f_t1, sos}, 8'h00);
    sot <= 1'b0;
    s_we <= 1'b1;
    s_d <= 2'h3;
    @(posedge clk_sys_i);
    s_we <= 1'b0;
    sot <= 1'b1;
    cyc(6);
    cv({4'h0, sen, f_t1, sos}, 8'h03);
    obey <= 1'b0;
    clq(4);
    cb(f_t1, 1'b1);
    sot <= 1'b0;
    obey <= 1'b1;
    cyc(4);
    clq(4);
    clq(5);
    cv({6'h00, f_t1, sos}, 8'h00);
    canon <= 1'b1;
    cot <= 1'b1;
    cyc(6);
    cv({5'h00, tx, cf}, 8'h01);
    cb(f_t1, 1'b1);
    cot <= 1'b0;
    cyc(6);
    cb(tx, 1'b1);
    clq(6);
    clq(4);
    cv({5'h00, f_t1, cf}, 8'h00);
    b = 4'h1 << $urandom_range(0, 3);
    h_we <= 1'b1;
    h_d <= 4'($urandom) | b;
    @(posedge clk_sys_i);
    h_we <= 1'b0;
    hot <= b;
    cyc(6);
    cv({hsc, hsf}, {4'h0, b});
    hot <= 4'h0;
    cyc(4);
    clq(7);
    clq(4);
    cv({4'h0, hsf}, 8'h00);
    pw <= 1'b1;
    cyc(5);
    obey <= 1'b0;
    clq(8);
    cb(f_pw, 1'b1);
    obey <= 1'b1;
    pw <= 1'b0;
    cyc(4);
    clq(8);
    cb(f_pw, 1'b0);
    t2 <= 1'b1;
    wm(2'h3, 6);
    cv({5'h00, f_t2, ren, fo}, 8'h05);
    t2 <= 1'b0;
    pw <= 1'b1;
    cyc(5);
    cb(f_pw, 1'b0);
    pw <= 1'b0;
    clq(9);
    cb(f_t2, 1'b1);
    wm(2'h0, CD + 10);
    wm(2'h1, RD + 20);
    clq(9);
    clq(1);
    cv({6'h00, f_t2, fo}, 8'h00);
    test_done();
  end
endmodule : tb_top
